// *** cfg_chain_pkg.sv ***
// shared constants for the serial configuration chain
package cfg_chain_pkg;
  localparam int SETUP_BITS_DEF   = 32;
  localparam int SYS_CLK_NS       = 20;
  localparam int LINK_DIV_DEF     = 4;
  localparam int SYNC_STAGES      = 2;
  localparam logic [1:0] PROG_SERIAL  = 2'h0;
  localparam logic [1:0] PROG_DEFAULT = 2'h1;
endpackage

// *** cfg_chain_if.sv ***
// interface joining the host controller and the configuration loader
`timescale 1ns/1ps
`default_nettype none
interface cfg_chain_if;
  logic sclk;
  logic chain_enable_in_n;
  logic serial_in;
  logic chain_enable_out_n;
  logic serial_out;
  logic device_master_reset_n;
  logic serial_mode;
  modport device (
    input  sclk, chain_enable_in_n, serial_in, device_master_reset_n, serial_mode,
    output chain_enable_out_n, serial_out
  );
  modport host (
    output sclk, chain_enable_in_n, serial_in, device_master_reset_n, serial_mode,
    input  chain_enable_out_n, serial_out
  );
endinterface
`default_nettype wire

// *** cfg_chain_loader.sv ***
// device end: serial setup loader with chain enable and pass-through
// Notes on behaviour
// - shift only when serial mode chosen
// - capture input bit on rising clock, enable low
// - setup held in serially filled shift register
// - chain enable out marks programming finished
// - when done, enable out copies enable in
// - low enable out lets next device load
// - queue operation ready once enable out low
// - when done and out low, pass data through
// - serial out feeds later chain devices
// - host feeds stream to first device only
// - chain enable out feeds next enable in
// - host drives first device enable directly
// - host watches last device enable out
// - all devices share one serial clock
// - last device serial out left open
// - no queue strobes before enable out low
`timescale 1ns/1ps
`default_nettype none
module cfg_chain_loader #(
  parameter int SETUP_BITS = cfg_chain_pkg::SETUP_BITS_DEF
) (
  // system side
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  output logic [SETUP_BITS-1:0]      setup_q,
  output logic                       queues_ready_q,
  // link side
  cfg_chain_if.device                lnk
);
  // parameter limits: the shift needs two bits, the counter a sane width
  if (SETUP_BITS < 2) begin : g_bits_low
    $error("SETUP_BITS must be at least 2");
  end
  if (SETUP_BITS > 4096) begin : g_bits_high
    $error("SETUP_BITS must not exceed 4096");
  end

  // fewer than two stages would let a metastable level reach logic
  if (cfg_chain_pkg::SYNC_STAGES < 2) begin : g_sync_short
    $error("SYNC_STAGES must be at least 2");
  end

  // counter width with one spare code, so a full count still fits
  localparam int CW = $clog2(SETUP_BITS + 1);

  // depth of the ready synchroniser into the system clock
  localparam int SW = cfg_chain_pkg::SYNC_STAGES;

  // link-side load phases; master reset always returns to loading
  typedef enum logic [0:0] {
    ST_LOAD = 1'b0,
    ST_DONE = 1'b1
  } load_state_t;

  // programming code chosen by the mode strap
  function automatic logic [1:0] strap_code(input logic serial_strap);
    if (serial_strap) begin
      strap_code = cfg_chain_pkg::PROG_SERIAL;
    end else begin
      strap_code = cfg_chain_pkg::PROG_DEFAULT;
    end
  endfunction

  // serial programming decode, shared by the bit taker and the phase logic
  function automatic logic is_serial(input logic [1:0] code);
    is_serial = (code == cfg_chain_pkg::PROG_SERIAL);
  endfunction

  // link domain state
  logic [1:0]            mode_q;
  load_state_t           state_q;
  load_state_t           state_d;
  logic [SETUP_BITS-1:0] shreg_q;
  logic [CW-1:0]         cnt_q;
  logic                  enable_out_q;
  logic                  loaded;
  logic                  take_bit;

  // system domain state
  logic [SW-1:0]         rdy_sync_q;
  logic                  rdy_level;

  // mode strap caught while master reset is held; it holds until the next one
  always_ff @(posedge lnk.sclk) begin
    if (!lnk.device_master_reset_n) begin
      mode_q <= strap_code(lnk.serial_mode);
    end
  end

  // a bit is taken only while loading in serial mode with enable in low
  assign take_bit = (state_q == ST_LOAD) && is_serial(mode_q)
                    && !lnk.chain_enable_in_n;

  // one decode of the finished phase for enable out and pass-through
  assign loaded = (state_q == ST_DONE);

  // next phase: default mode finishes on the first edge out of reset
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_LOAD: begin
        if (!is_serial(mode_q)) begin
          state_d = ST_DONE;
        end else if (take_bit && (cnt_q == CW'(SETUP_BITS - 1))) begin
          state_d = ST_DONE;
        end
      end
      ST_DONE: begin
        // done holds until the next master reset
        state_d = ST_DONE;
      end
      default: begin
        state_d = ST_LOAD;
      end
    endcase
  end

  // phase register
  always_ff @(posedge lnk.sclk) begin
    if (!lnk.device_master_reset_n) begin
      state_q <= ST_LOAD;
    end else begin
      state_q <= state_d;
    end
  end

  // setup shift register; the first bit sent ends at the top
  always_ff @(posedge lnk.sclk) begin
    if (!lnk.device_master_reset_n) begin
      shreg_q <= '0;
    end else if (take_bit) begin
      shreg_q <= {shreg_q[SETUP_BITS-2:0], lnk.serial_in};
    end
  end

  // bits taken so far; frozen once loaded, later bits are only passed on
  always_ff @(posedge lnk.sclk) begin
    if (!lnk.device_master_reset_n) begin
      cnt_q <= '0;
    end else if (take_bit) begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  // enable out held high until loaded, then follows the input a cycle late
  always_ff @(posedge lnk.sclk) begin
    if (!lnk.device_master_reset_n) begin
      enable_out_q <= 1'b1;
    end else if (loaded) begin
      enable_out_q <= lnk.chain_enable_in_n;
    end else begin
      enable_out_q <= 1'b1;
    end
  end
  assign lnk.chain_enable_out_n = enable_out_q;

  // combinational pass-through; a register here would add a bit per device
  assign lnk.serial_out = (loaded && !enable_out_q) ? lnk.serial_in : 1'b0;

  // enable out is low only when loaded, so one flop carries ready glitch-free
  assign rdy_level = ~enable_out_q;

  // ready level crossed into the system clock; only the last stage is read
  for (genvar s = 0; s < SW; s++) begin : g_rdy_sync
    if (s == 0) begin : g_first
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          rdy_sync_q[0] <= 1'b0;
        end else begin
          rdy_sync_q[0] <= rdy_level;
        end
      end
    end else begin : g_next
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          rdy_sync_q[s] <= 1'b0;
        end else begin
          rdy_sync_q[s] <= rdy_sync_q[s-1];
        end
      end
    end
  end

  // queue operation allowed once the crossed ready level stands
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      queues_ready_q <= 1'b0;
    end else begin
      queues_ready_q <= rdy_sync_q[SW-1];
    end
  end

  // setup is frozen once loaded, so taking it on the ready rise is safe;
  // a later master reset keeps the old word until ready rises again
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      setup_q <= '0;
    end else if (rdy_sync_q[SW-1] && !queues_ready_q) begin
      setup_q <= shreg_q;
    end
  end
endmodule
`default_nettype wire

// *** cfg_chain_host.sv ***
// host end: drives serial clock, enable and setup stream
`timescale 1ns/1ps
`default_nettype none
module cfg_chain_host #(
  parameter int SETUP_BITS = cfg_chain_pkg::SETUP_BITS_DEF,
  parameter int LINK_DIV   = cfg_chain_pkg::LINK_DIV_DEF
) (
  // system side
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire logic                  start,
  input  wire logic                  serial_sel,
  input  wire logic [SETUP_BITS-1:0] setup_word,
  output logic                       busy_q,
  output logic                       all_loaded_q,
  // link side
  cfg_chain_if.host                  lnk
);
  // refuse dividers that cannot give a square link clock
  if (LINK_DIV < 2 || LINK_DIV % 2 != 0) begin : g_bad_div
    $error("LINK_DIV must be even, >= 2");
  end

  // the sender shifts a word, so it needs two bits at least
  if (SETUP_BITS < 2) begin : g_bad_bits
    $error("SETUP_BITS must be at least 2");
  end

  localparam int DW = $clog2(LINK_DIV);
  localparam int CW = $clog2(SETUP_BITS + 2);

  logic [DW-1:0]         div_q;
  logic                  sclk_q;
  logic                  enable_in_q;
  logic                  si_q;
  logic                  master_reset_q;
  logic                  reset_seen_q;
  logic                  mode_q;
  logic [SETUP_BITS-1:0] data_q;
  logic [CW-1:0]         cnt_q;
  logic [1:0]            enable_out_sync_q;
  logic                  fall_tick;
  logic                  rise_tick;

  // link clock from a divider; data changes on falling link edge
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      div_q  <= '0;
      sclk_q <= 1'b0;
    end else if (div_q == DW'(LINK_DIV / 2 - 1)) begin
      div_q  <= '0;
      sclk_q <= ~sclk_q;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end
  // divider end ticks, told apart by the link clock level before them
  assign fall_tick = (div_q == DW'(LINK_DIV / 2 - 1)) && sclk_q;
  assign rise_tick = (div_q == DW'(LINK_DIV / 2 - 1)) && !sclk_q;

  // master reset is let go only after a link rise has surely seen it low
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reset_seen_q <= 1'b0;
    end else if (master_reset_q) begin
      reset_seen_q <= 1'b0;
    end else if (rise_tick) begin
      reset_seen_q <= 1'b1;
    end
  end

  // load sequence: reset pulse, then one bit per link cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      busy_q         <= 1'b0;
      enable_in_q    <= 1'b1;
      si_q           <= 1'b0;
      master_reset_q <= 1'b1;
      mode_q         <= 1'b0;
      data_q         <= '0;
      cnt_q          <= '0;
    end else if (!busy_q) begin
      if (start) begin
        busy_q         <= 1'b1;
        enable_in_q    <= 1'b1; // no stale bit may be taken before the first
        master_reset_q <= 1'b0;
        mode_q         <= serial_sel;
        data_q         <= setup_word;
        cnt_q          <= '0;
      end
    end else if (fall_tick) begin
      if (!master_reset_q) begin
        if (reset_seen_q) begin
          master_reset_q <= 1'b1;
        end
      end else if (cnt_q < CW'(SETUP_BITS)) begin
        enable_in_q <= 1'b0;
        si_q        <= data_q[SETUP_BITS-1];
        data_q      <= {data_q[SETUP_BITS-2:0], 1'b0};
        cnt_q       <= cnt_q + CW'(1);
      end else begin
        enable_in_q <= 1'b0; // enable held low so the chain stays ready
        busy_q      <= 1'b0;
      end
    end
  end

  // watch last enable out, crossed in by two flops
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      enable_out_sync_q <= 2'h3;
      all_loaded_q      <= 1'b0;
    end else begin
      enable_out_sync_q <= {enable_out_sync_q[0], lnk.chain_enable_out_n};
      all_loaded_q      <= ~enable_out_sync_q[1];
    end
  end

  assign lnk.sclk                  = sclk_q;
  assign lnk.chain_enable_in_n     = enable_in_q;
  assign lnk.serial_in             = si_q;
  assign lnk.device_master_reset_n = master_reset_q;
  assign lnk.serial_mode           = mode_q;
endmodule
`default_nettype wire

// *** cfg_chain_properties.sv ***
// link assertions for the serial configuration chain
`timescale 1ns/1ps
`default_nettype none
module cfg_chain_properties #(
  parameter int SETUP_BITS = cfg_chain_pkg::SETUP_BITS_DEF
) (
  // link signals
  input wire logic sclk,
  input wire logic chain_enable_in_n,
  input wire logic serial_in,
  input wire logic chain_enable_out_n,
  input wire logic serial_out,
  input wire logic device_master_reset_n,
  input wire logic serial_mode
);
  logic [7:0] bits_q;
  logic       done_q;
  default clocking cb @(posedge sclk); endclocking
  default disable iff (!device_master_reset_n);
  // shadow bit count, serial mode only; default timing is left to p_default
  always_ff @(posedge sclk) begin
    if (!device_master_reset_n) begin
      bits_q <= 8'h00;
      done_q <= 1'b0;
    end else if (serial_mode && !chain_enable_in_n && !done_q) begin
      bits_q <= bits_q + 8'h01;
      done_q <= (bits_q == 8'(SETUP_BITS - 1));
    end
  end
  property p_hold; serial_mode && !done_q |-> chain_enable_out_n; endproperty
  property p_follow;
    serial_mode && done_q |=> chain_enable_out_n == $past(chain_enable_in_n);
  endproperty
  property p_pass; !chain_enable_out_n |-> serial_out == serial_in; endproperty
  property p_block; chain_enable_out_n |-> serial_out == 1'b0; endproperty
  property p_default;
    !serial_mode && !chain_enable_in_n [*5] |-> !chain_enable_out_n;
  endproperty
  property p_rise; done_q && $rose(chain_enable_in_n) |=> chain_enable_out_n; endproperty
  property p_fell; $fell(chain_enable_out_n) |-> !$past(chain_enable_in_n); endproperty
  property p_count; serial_mode && $fell(chain_enable_out_n) |-> $past(done_q); endproperty
  a_hold: assert property (p_hold) else $error("enable out low early");
  a_follow: assert property (p_follow) else $error("enable out not following");
  a_pass: assert property (p_pass) else $error("no pass through");
  a_block: assert property (p_block) else $error("serial out not quiet");
  a_default: assert property (p_default) else $error("default load hangs");
  a_rise: assert property (p_rise) else $error("enable out stuck low");
  a_fell: assert property (p_fell) else $error("enable out fell alone");
  a_count: assert property (p_count) else $error("bit count wrong");
  c_done: cover property (done_q && !chain_enable_out_n);
  c_default: cover property (!serial_mode && !chain_enable_out_n);
  c_load: cover property ($rose(done_q));
endmodule
`default_nettype wire

// *** test_serial_config_chain_loader.sv ***
// self-checking bench: host and loader joined over the chain link
`timescale 1ns/1ps
`default_nettype none
module test_serial_config_chain_loader;
  logic       mclk, rst_n, start, serial_sel, busy_q, all_loaded_q, queues_ready_q;
  logic [7:0] setup_word, setup_q;
  logic [2:0] flags;
  int         n_errors, checked;
  // lone device: enable out returns to the host, serial out only to the checker
  cfg_chain_if lnk ();
  cfg_chain_host #(.SETUP_BITS(8)) i_cfg_chain_host (.mclk(mclk), .rst_n(rst_n),
    .start(start), .serial_sel(serial_sel), .setup_word(setup_word), .busy_q(busy_q),
    .all_loaded_q(all_loaded_q), .lnk(lnk.host));
  cfg_chain_loader #(.SETUP_BITS(8)) i_cfg_chain_loader (.mclk(mclk), .rst_n(rst_n),
    .setup_q(setup_q), .queues_ready_q(queues_ready_q), .lnk(lnk.device));
  cfg_chain_properties #(.SETUP_BITS(8)) i_cfg_chain_properties (.sclk(lnk.sclk),
    .chain_enable_in_n(lnk.chain_enable_in_n), .serial_in(lnk.serial_in),
    .chain_enable_out_n(lnk.chain_enable_out_n), .serial_out(lnk.serial_out),
    .device_master_reset_n(lnk.device_master_reset_n), .serial_mode(lnk.serial_mode));
  assign flags = {queues_ready_q, all_loaded_q, busy_q};
  initial begin
    mclk = 1'b0;
    forever #(cfg_chain_pkg::SYS_CLK_NS / 2) mclk = ~mclk;
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // bounded poll, one look per cycle just after the edge
  task automatic wait_for(input int idx, input logic lvl);
    for (int i = 0; i < 2000; i++) begin
      @(posedge mclk);
      #1;
      if (flags[idx] === lvl) return;
    end
    chk({5'h00, flags}, 8'hFF);
    end_sim();
  endtask
  // one full load; the host sends msb first, so in serial mode setup_q ends equal to the word
  task automatic t_load(input logic [7:0] word, input logic sel);
    setup_word = word;
    serial_sel = sel;
    start = 1'b1;
    @(posedge mclk);
    #1 start = 1'b0;
    wait_for(0, 1'b1);
    wait_for(0, 1'b0);
    if (sel) chk({7'h00, all_loaded_q}, 8'h00);
    wait_for(1, 1'b1);
    wait_for(2, 1'b1);
    chk({5'h00, flags}, 8'h06);
    if (sel) chk(setup_q, word);
  endtask
  task automatic t_serial_load;
    t_load(8'hA5, 1'b1);
    $display("serial load finished");
  endtask
  task automatic t_default_load;
    t_load(8'hFF, 1'b0);
    chk({7'h00, all_loaded_q}, 8'h01);
    chk(setup_q, 8'h00);
    $display("default load finished");
  endtask
  // back-to-back reloads with edge bit patterns
  task automatic t_reload;
    t_load(8'h81, 1'b1);
    t_load(8'h7E, 1'b1);
    chk(setup_q, 8'h7E);
    $display("reload finished");
  endtask
  initial begin
    rst_n = 1'b0;
    start = 1'b0;
    serial_sel = 1'b1;
    setup_word = 8'h00;
    n_errors = 0;
    checked = 0;
    repeat (3) @(posedge mclk);
    #1 rst_n = 1'b1;
    @(posedge mclk);
    #1;
    t_serial_load();
    t_default_load();
    t_reload();
    end_sim();
  end
endmodule
`default_nettype wire
